// *** bench/eic_core_model.sv ***
// core model: reports instruction boundaries every few cycles
`timescale 1ns/100ps
module eic_core_model #(
    parameter int PERIOD = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic insn_done
);
    int cnt_q;
    // a longer period models a slow multi-state instruction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
        end
    end
    assign insn_done = (cnt_q == PERIOD - 1);
endmodule

// *** bench/eic_top_checker.sv ***
// port assertions for the edge interrupt controller
`timescale 1ns/100ps
module eic_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic handler_active,
    input wire logic stack_push,
    input wire logic [4:0] vector_addr,
    input wire logic mask_q_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // --------------------------------
    // bus and sequencer
    // --------------------------------
    ready_after_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than a cycle");
    bad_addr_a: assert property (psel && !penable && paddr > 12'h02c |=> pslverr)
        else $error("no error on bad address");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    stack_len_a: assert property ($rose(stack_push) |-> stack_push [*4] ##1 !stack_push)
        else $error("stacking not four cycles");
    stack_mask_a: assert property (stack_push |-> mask_q_out)
        else $error("mask clear during stacking");
    handler_time_a: assert property ($fell(stack_push) |-> ##10 handler_active)
        else $error("handler start late");
    handler_vec_a: assert property (handler_active |-> vector_addr inside {[5'h03:5'h17]})
        else $error("vector out of range");
    handler_pulse_a: assert property (handler_active |=> !handler_active)
        else $error("handler pulse too long");
    cv_stack: cover property ($rose(stack_push));
    cv_handler: cover property (handler_active);
    cv_err: cover property (pslverr);
endmodule
bind eic_top eic_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .handler_active(handler_active),
    .stack_push(stack_push), .vector_addr(vector_addr), .mask_q_out(mask_q_out));

// *** bench/test_edge_interrupt_controller.sv ***
// self-checking bench for the edge interrupt controller
`timescale 1ns/100ps
`include "eic_map.vh"
module test_edge_interrupt_controller;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, handler_active, stack_push, mask_q_out, insn_done;
    logic nmi_pin = 1'b0;
    logic [3:0] port_pins = 4'h0;
    logic [7:0] shared_pins = 8'h00;
    logic [14:0] periph_req = 15'h0;
    logic [7:0] tb2_count = 8'h00;
    logic [4:0] vector_addr;
    int failures = 0;
    int comparisons = 0;
    always #20 pclk = ~pclk;
    eic_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nmi_pin(nmi_pin), .port_select_request_pins(port_pins),
        .shared_vector_pins(shared_pins), .periph_req(periph_req), .tb2_count(tb2_count),
        .insn_done(insn_done), .handler_active(handler_active), .stack_push(stack_push),
        .vector_addr(vector_addr), .mask_q_out(mask_q_out));
    eic_core_model core (.pclk(pclk), .presetn(presetn), .insn_done(insn_done));
    // --------------------------------
    // helpers
    // --------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready and prdata are taken at the edge, before the design moves them
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk({31'h0, pready}, 32'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask
    task cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // waits for the handler start and checks the vector taken
    task wait_handler(input logic [4:0] vec);
        int n;
        n = 0;
        while (handler_active !== 1'b1 && n < 300) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk({31'h0, handler_active}, 32'h1);
        chk({27'h0, vector_addr}, {27'h0, vec});
        chk({31'h0, mask_q_out}, 32'h1);
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task reset_and_bad_addr;
        logic [31:0] r;
        logic e;
        rd(`EIC_OFF_IRQ_FLAGS1, 32'h10);
        rd(`EIC_OFF_IRQ_FLAGS2, 32'h00);
        rd(`EIC_OFF_PIN_FLAGS, 32'h00);
        apb(1'b0, 12'h030, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        apb(1'b0, 12'h006, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
    endtask
    task shared_pin_accept;
        wr(`EIC_OFF_CORE, 32'h1);
        wr(`EIC_OFF_EDGE2, 32'hff);
        wr(`EIC_OFF_ENABLE3, 32'h08);
        @(posedge pclk);
        shared_pins <= 8'h08;
        cycles(6);
        rd(`EIC_OFF_PIN_FLAGS, 32'h08);
        rd(`EIC_OFF_CORE, 32'h00000001);
        wr(`EIC_OFF_CORE, 32'h12340000);
        wait_handler(`EIC_VEC_SHARED);
        rd(`EIC_OFF_STACKED, 32'h12340000);
        rd(`EIC_OFF_CORE, 32'h12340011);
        rd(`EIC_OFF_PIN_FLAGS, 32'h08);
        wr(`EIC_OFF_PIN_FLAGS, 32'hff);
        rd(`EIC_OFF_PIN_FLAGS, 32'h08);
        wr(`EIC_OFF_PIN_FLAGS, 32'h00);
        rd(`EIC_OFF_PIN_FLAGS, 32'h00);
        wr(`EIC_OFF_EDGE2, 32'h00);
        @(posedge pclk);
        shared_pins <= 8'h00;
        cycles(6);
        rd(`EIC_OFF_PIN_FLAGS, 32'h08);
        wr(`EIC_OFF_PIN_FLAGS, 32'h00);
    endtask
    task nmi_masked;
        wr(`EIC_OFF_EDGE1, 32'h80);
        @(posedge pclk);
        nmi_pin <= 1'b1;
        wait_handler(`EIC_VEC_NMI);
    endtask
    task port_priority;
        wr(`EIC_OFF_PORT_MODE, 32'h07);
        wr(`EIC_OFF_EDGE1, 32'h8f);
        wr(`EIC_OFF_ENABLE1, 32'h0f);
        @(posedge pclk);
        port_pins <= 4'he;
        periph_req <= 15'h4000;
        cycles(6);
        rd(`EIC_OFF_IRQ_FLAGS1, 32'h16);
        wr(`EIC_OFF_CORE, 32'h0);
        wait_handler(5'h05);
        wr(`EIC_OFF_IRQ_FLAGS1, 32'hfd);
        rd(`EIC_OFF_IRQ_FLAGS1, 32'h14);
        wr(`EIC_OFF_CORE, 32'h0);
        wait_handler(5'h06);
    endtask
    task timer_rollover;
        wr(`EIC_OFF_ENABLE2, 32'h01);
        @(posedge pclk);
        tb2_count <= 8'hff;
        @(posedge pclk);
        tb2_count <= 8'h00;
        cycles(4);
        rd(`EIC_OFF_IRQ_FLAGS2, 32'h01);
        wr(`EIC_OFF_IRQ_FLAGS1, 32'h00);
        wr(`EIC_OFF_CORE, 32'h0);
        wait_handler(`EIC_VEC_INT_TOP);
    endtask
    task wrap_up;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        cycles(3);
        presetn <= 1'b1;
        reset_and_bad_addr();
        shared_pin_accept();
        nmi_masked();
        port_priority();
        timer_rollover();
        wrap_up();
    end
    initial begin
        #400000;
        failures++;
        wrap_up();
    end
endmodule

// *** verilog/eic_map.vh ***
// register map, field layout and timing constants of the edge interrupt controller
// Contract
// - timer-B2 flag sets when its 8-bit counter rolls from ff to 00.
// - 8-bit pin-edge flag register, one flag per shared pin, resets to 00.
// - flags survive acceptance; only a written zero clears, a one does nothing.
// - shared pin flags set on selected edge even in general port use.
// - nonmaskable edge selectable, top priority, ignores mask, vector 3.
// - port request pins edge selectable; flag sets only when pin is interrupt input.
// - port requests have own enables; all masked while global mask is one.
// - port requests use vectors 7 down to 4, request 0 highest.
// - shared pins edge selectable by bits of second edge-select register.
// - shared requests have own enables and are masked by global mask.
// - all shared pin requests use vector 8; handler reads flags.
// - 11 internal requests, flags in first/second registers, vectors 23 to 9.
// - a request condition sets its flag only while its enable bit is one; shared pin flags set regardless of enable3.
// - highest priority set flag is chosen, others stay pending.
// - maskable request accepted when mask is zero, held while one.
// - on acceptance, after the instruction, push program counter and condition register.
// - entering any interrupt handling sets the global mask bit.
// - vector address generated, handler address read, execution continues there; the code only drives vector_addr, and pc_q is never loaded from handler_q.
// - response: 1..13 finish, 4 stack, 2 vector, 4 fetch, 4 internal states.
// - a clear colliding with a request still lets the interrupt be taken; code covers enable clears with mask zero, lost if another is taken first.
`ifndef EIC_MAP_VH
`define EIC_MAP_VH

`define EIC_OFF_IRQ_FLAGS1 12'h000
`define EIC_OFF_IRQ_FLAGS2 12'h004
`define EIC_OFF_PIN_FLAGS 12'h008
`define EIC_OFF_EDGE1 12'h00c
`define EIC_OFF_EDGE2 12'h010
`define EIC_OFF_ENABLE1 12'h014
`define EIC_OFF_ENABLE2 12'h018
`define EIC_OFF_ENABLE3 12'h01c
`define EIC_OFF_PORT_MODE 12'h020
`define EIC_OFF_CORE 12'h024
`define EIC_OFF_STACKED 12'h028
`define EIC_OFF_HANDLER 12'h02c

`define EIC_RST_FLAGS1 8'h10
`define EIC_RST_FLAGS2 8'h00
`define EIC_RST_PIN_FLAGS 8'h00
`define EIC_FLAGS1_RSVD 4
`define EIC_EDGE1_NMI 7
`define EIC_FLAGS2_TB2 0
`define EIC_CORE_MASK 0
`define EIC_CORE_PC_LSB 16

`define EIC_VEC_NMI 5'h03
`define EIC_VEC_PORT0 5'h04
`define EIC_VEC_SHARED 5'h08
`define EIC_VEC_INT_TOP 5'h17
`define EIC_VEC_INT_BOT 5'h09

`define EIC_ST_STACK 3'h4
`define EIC_ST_VECTOR 3'h2
`define EIC_ST_FETCH 3'h4
`define EIC_ST_INTERNAL 3'h4

`endif

// *** verilog/eic_top.v ***
// edge interrupt controller with its apb register file and exception sequencer
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/100ps
`include "eic_map.vh"

module eic_top (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    nmi_pin,
    port_select_request_pins,
    shared_vector_pins,
    periph_req,
    tb2_count,
    insn_done,
    handler_active,
    stack_push,
    vector_addr,
    mask_q_out
);
    input wire pclk;
    input wire presetn;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [11:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output reg pready;
    output reg pslverr;
    input wire nmi_pin;
    input wire [3:0] port_select_request_pins;
    input wire [7:0] shared_vector_pins;
    input wire [14:0] periph_req;
    input wire [7:0] tb2_count;
    input wire insn_done;
    output reg handler_active;
    output reg stack_push;
    output reg [4:0] vector_addr;
    output reg mask_q_out;

    // ----------------------------------------------------------------
    // state and register declarations
    // ----------------------------------------------------------------
    localparam S_IDLE = 3'd0;
    localparam S_WAIT = 3'd1;
    localparam S_STACK = 3'd2;
    localparam S_VECT = 3'd3;
    localparam S_FETCH = 3'd4;
    localparam S_INTL = 3'd5;

    reg [2:0] state_q;
    reg [2:0] cnt_q;
    reg [7:0] flags1_q;
    reg [7:0] flags2_q;
    reg [7:0] pin_edge_request_flags_q;
    reg [7:0] edge_select_reg_one_q;
    reg [7:0] edge_select_reg_two_q;
    reg [7:0] enable_reg_one_q;
    reg [7:0] enable_reg_two_q;
    reg [7:0] enable_reg_three_q;
    reg [3:0] port_mode_q;
    reg [15:0] pc_q;
    reg [15:0] stacked_pc_q;
    reg [7:0] stacked_ccr_q;
    reg [15:0] handler_q;
    reg nmi_pend_q;
    reg [4:0] acc_vec_q;
    reg [12:0] sync1_q;
    reg [12:0] sync2_q;
    reg [12:0] prev_q;
    reg [7:0] tb2_prev_q;
    reg [14:0] preq_prev_q;

    wire wr_en = psel & penable & pwrite;
    wire rd_en = psel & ~penable & ~pwrite;

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    // bit 12 is the nonmaskable pin, 11..8 port pins, 7..0 shared pins
    wire [12:0] pins_raw = {nmi_pin, port_select_request_pins, shared_vector_pins};
    wire [12:0] sel_edge = {edge_select_reg_one_q[`EIC_EDGE1_NMI],
                            edge_select_reg_one_q[3:0], edge_select_reg_two_q};
    wire [12:0] pin_edge;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 13'h0000;
            sync2_q <= 13'h0000;
            prev_q <= 13'h0000;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // edge bit one selects rising, zero falling
    genvar gi;
    generate
        for (gi = 0; gi < 13; gi = gi + 1) begin : g_edge
            assign pin_edge[gi] = sel_edge[gi] ? (sync2_q[gi] & ~prev_q[gi])
                                               : (~sync2_q[gi] & prev_q[gi]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // request flag set terms
    // ----------------------------------------------------------------
    // peripheral requests are rising-edge events; 10 of the internal sources
    // live in these flags, timer b2 comes from its counter rollover
    wire [14:0] preq_rise = periph_req & ~preq_prev_q;
    wire tb2_roll = (tb2_prev_q == 8'hff) && (tb2_count == 8'h00);

    wire [7:0] set1 = {preq_rise[14:12] & enable_reg_one_q[7:5], 1'b0,
                       pin_edge[11:8] & port_mode_q & enable_reg_one_q[3:0]};
    wire [7:0] set2 = {preq_rise[11:5] & enable_reg_two_q[7:1],
                       tb2_roll & enable_reg_two_q[`EIC_FLAGS2_TB2]};
    // shared pins flag in both port and interrupt use of the pin
    wire [7:0] set3 = pin_edge[7:0];

    // clear-on-zero: written zero clears, set of the same cycle wins
    function [7:0] w0c;
        input [7:0] cur;
        input [7:0] setv;
        input wr;
        input [7:0] data;
        begin
            w0c = (wr ? (cur & data) : cur) | setv;
        end
    endfunction

    // ----------------------------------------------------------------
    // enable clear collisions
    // ----------------------------------------------------------------
    // a request that lands in the cycle its enable is written to zero
    // with the mask open is still taken once: the late bit stands in
    // for the lost enable until the flag clears or any source is
    // accepted, so a late request can be lost behind a higher one
    wire take_ack = (state_q == S_WAIT) & insn_done;
    wire en1_clr = wr_en && (paddr == `EIC_OFF_ENABLE1) && !mask_q_out;
    wire en2_clr = wr_en && (paddr == `EIC_OFF_ENABLE2) && !mask_q_out;
    wire en3_clr = wr_en && (paddr == `EIC_OFF_ENABLE3) && !mask_q_out;
    wire [7:0] coll1 = set1 & ~pwdata[7:0] & {8{en1_clr}};
    wire [7:0] coll2 = set2 & ~pwdata[7:0] & {8{en2_clr}};
    wire [7:0] coll3 = set3 & enable_reg_three_q & ~pwdata[7:0] & {8{en3_clr}};
    reg [7:0] late1_q;
    reg [7:0] late2_q;
    reg [7:0] late3_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            late1_q <= 8'h00;
            late2_q <= 8'h00;
            late3_q <= 8'h00;
        end else begin
            // a new collision wins over the clear at acceptance
            late1_q <= (take_ack ? 8'h00 : late1_q & flags1_q) | coll1;
            late2_q <= (take_ack ? 8'h00 : late2_q & flags2_q) | coll2;
            late3_q <= (take_ack ? 8'h00 : late3_q & pin_edge_request_flags_q) | coll3;
        end
    end

    // ----------------------------------------------------------------
    // priority selection
    // ----------------------------------------------------------------
    wire [7:0] act1 = flags1_q & (enable_reg_one_q | late1_q) & 8'hef;
    wire [7:0] act2 = flags2_q & (enable_reg_two_q | late2_q);
    wire [7:0] act3 = pin_edge_request_flags_q & (enable_reg_three_q | late3_q);
    wire mask_i = mask_q_out;

    reg [4:0] sel_vec;
    reg sel_any;
    integer k;
    always @* begin
        sel_vec = 5'h00;
        sel_any = 1'b0;
        // internal sources, lowest priority first so later wins
        for (k = 0; k < 8; k = k + 1) begin
            if (act2[k]) begin
                sel_any = 1'b1;
                sel_vec = `EIC_VEC_INT_TOP - k[4:0];
            end
        end
        for (k = 5; k < 8; k = k + 1) begin
            if (act1[k]) begin
                sel_any = 1'b1;
                sel_vec = `EIC_VEC_INT_BOT + 5'h07 - k[4:0];
            end
        end
        if (act3 != 8'h00) begin
            sel_any = 1'b1;
            sel_vec = `EIC_VEC_SHARED;
        end
        for (k = 3; k >= 0; k = k - 1) begin
            if (act1[k]) begin
                sel_any = 1'b1;
                sel_vec = `EIC_VEC_PORT0 + k[4:0];
            end
        end
    end

    wire take_nmi = nmi_pend_q;
    wire take_mask = sel_any & ~mask_i;

    // ----------------------------------------------------------------
    // flag registers and apb writes
    // ----------------------------------------------------------------
    wire nmi_ack = (state_q == S_WAIT) & insn_done & (acc_vec_q == `EIC_VEC_NMI);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags1_q <= `EIC_RST_FLAGS1;
            flags2_q <= `EIC_RST_FLAGS2;
            pin_edge_request_flags_q <= `EIC_RST_PIN_FLAGS;
            edge_select_reg_one_q <= 8'h00;
            edge_select_reg_two_q <= 8'h00;
            enable_reg_one_q <= 8'h00;
            enable_reg_two_q <= 8'h00;
            enable_reg_three_q <= 8'h00;
            port_mode_q <= 4'h0;
            pc_q <= 16'h0000;
            handler_q <= 16'h0000;
            nmi_pend_q <= 1'b0;
            tb2_prev_q <= 8'h00;
            preq_prev_q <= 15'h0000;
        end else begin
            tb2_prev_q <= tb2_count;
            preq_prev_q <= periph_req;
            flags1_q <= w0c(flags1_q, set1,
                            wr_en && paddr == `EIC_OFF_IRQ_FLAGS1, pwdata[7:0]) | 8'h10;
            flags2_q <= w0c(flags2_q, set2,
                            wr_en && paddr == `EIC_OFF_IRQ_FLAGS2, pwdata[7:0]);
            pin_edge_request_flags_q <= w0c(pin_edge_request_flags_q, set3,
                                            wr_en && paddr == `EIC_OFF_PIN_FLAGS,
                                            pwdata[7:0]);
            if (pin_edge[12])
                nmi_pend_q <= 1'b1;
            else if (nmi_ack)
                nmi_pend_q <= 1'b0;
            if (wr_en) begin
                case (paddr)
                    `EIC_OFF_EDGE1: edge_select_reg_one_q <= pwdata[7:0];
                    `EIC_OFF_EDGE2: edge_select_reg_two_q <= pwdata[7:0];
                    `EIC_OFF_ENABLE1: enable_reg_one_q <= pwdata[7:0];
                    `EIC_OFF_ENABLE2: enable_reg_two_q <= pwdata[7:0];
                    `EIC_OFF_ENABLE3: enable_reg_three_q <= pwdata[7:0];
                    `EIC_OFF_PORT_MODE: port_mode_q <= pwdata[3:0];
                    `EIC_OFF_CORE: pc_q <= pwdata[31:16];
                    `EIC_OFF_HANDLER: handler_q <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // exception sequencer
    // ----------------------------------------------------------------
    // stands in for the core: waits for instruction end, then walks the
    // stacking, vector and fetch states before the handler runs
    reg [2:0] state_d;
    reg [2:0] cnt_d;
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q - 3'h1;
        case (state_q)
            S_IDLE: begin
                cnt_d = 3'h0;
                if (take_nmi | take_mask)
                    state_d = S_WAIT;
            end
            S_WAIT: begin
                cnt_d = `EIC_ST_STACK - 3'h1;
                if (insn_done)
                    state_d = S_STACK;
            end
            S_STACK: if (cnt_q == 3'h0) begin
                state_d = S_VECT;
                cnt_d = `EIC_ST_VECTOR - 3'h1;
            end
            S_VECT: if (cnt_q == 3'h0) begin
                state_d = S_FETCH;
                cnt_d = `EIC_ST_FETCH - 3'h1;
            end
            S_FETCH: if (cnt_q == 3'h0) begin
                state_d = S_INTL;
                cnt_d = `EIC_ST_INTERNAL - 3'h1;
            end
            S_INTL: if (cnt_q == 3'h0) begin
                state_d = S_IDLE;
                cnt_d = 3'h0;
            end
            default: begin
                state_d = S_IDLE;
                cnt_d = 3'h0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            cnt_q <= 3'h0;
            acc_vec_q <= 5'h00;
            mask_q_out <= 1'b0;
            stacked_pc_q <= 16'h0000;
            stacked_ccr_q <= 8'h00;
            stack_push <= 1'b0;
            vector_addr <= 5'h00;
            handler_active <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            stack_push <= (state_d == S_STACK);
            handler_active <= (state_q == S_INTL) && (cnt_q == 3'h0);
            if (state_q == S_IDLE && (take_nmi | take_mask))
                acc_vec_q <= take_nmi ? `EIC_VEC_NMI : sel_vec;
            if (state_q == S_WAIT && insn_done) begin
                stacked_pc_q <= pc_q;
                stacked_ccr_q <= {7'h00, mask_q_out};
                mask_q_out <= 1'b1;
            end
            if (state_d == S_VECT)
                vector_addr <= acc_vec_q;
            if (wr_en && paddr == `EIC_OFF_CORE && !(state_q == S_WAIT && insn_done))
                mask_q_out <= pwdata[`EIC_CORE_MASK];
        end
    end

    // ----------------------------------------------------------------
    // apb read path
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable) begin
                pslverr <= (paddr > `EIC_OFF_HANDLER) || (paddr[1:0] != 2'b00);
            end
            if (rd_en) begin
                case (paddr)
                    `EIC_OFF_IRQ_FLAGS1: prdata <= {24'h000000, flags1_q};
                    `EIC_OFF_IRQ_FLAGS2: prdata <= {24'h000000, flags2_q};
                    `EIC_OFF_PIN_FLAGS: prdata <= {24'h000000, pin_edge_request_flags_q};
                    `EIC_OFF_EDGE1: prdata <= {24'h000000, edge_select_reg_one_q};
                    `EIC_OFF_EDGE2: prdata <= {24'h000000, edge_select_reg_two_q};
                    `EIC_OFF_ENABLE1: prdata <= {24'h000000, enable_reg_one_q};
                    `EIC_OFF_ENABLE2: prdata <= {24'h000000, enable_reg_two_q};
                    `EIC_OFF_ENABLE3: prdata <= {24'h000000, enable_reg_three_q};
                    `EIC_OFF_PORT_MODE: prdata <= {28'h0000000, port_mode_q};
                    `EIC_OFF_CORE: prdata <= {pc_q, 10'h000, acc_vec_q, mask_q_out};
                    `EIC_OFF_STACKED: prdata <= {stacked_pc_q, 8'h00, stacked_ccr_q};
                    `EIC_OFF_HANDLER: prdata <= {16'h0000, handler_q};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule
